// *** analog_die_interrupt_protect.sv ***
// Interrupt, reset and protection-event logic of the analog companion die
//
// Summary of operation
// - Seven interrupt sources, each enabled separately
// - Any reset clears every interrupt enable
// - Low supply sets flag, interrupts if enabled
// - Low supply switches off all high-side stages
// - Low-supply detection disabled in stop mode
// - High supply sets flag, interrupts if enabled
// - High supply switches off all high-side stages
// - High-supply detection disabled in stop mode
// - Over-temperature sets flag, interrupts if enabled
// - Over-temperature detection disabled in stop mode
// - Internal reset source pulls reset line low
// - Reset line open-drain, two-way, wired to MCU
// - Open-drain active-low interrupt output to MCU
// - Only period taken from input; duty internal
// - High-side inrush limited by automatic PWM
// - Bridge current limiting on lower transistors
// - Received LIN level shown on receive output
// - LIN falling edge interrupts, wakes from stop
// - Overcurrent interrupts when its enable set
`include "die_irq_cfg.svh"
`default_nettype none

module analog_die_interrupt_protect #(
  parameter int PER_W = `PER_WIDTH
) (
  // Clock and reset
  input  wire  logic                ref_clk,
  input  wire  logic                rstn,
  // Enables written over the internal serial link, with write strobe
  input  wire  logic [`NUM_SRC-1:0] enable_wdata,
  input  wire  logic                enable_we,
  input  wire  logic [`NUM_SRC-1:0] flag_clear,
  output logic       [`NUM_SRC-1:0] irq_enable,
  output logic       [`NUM_SRC-1:0] irq_flag,
  // Mode and analog detector inputs (asynchronous)
  input  wire  logic                stop_mode,
  input  wire  logic                supply_low_det,
  input  wire  logic                supply_high_det,
  input  wire  logic                temp_high_det,
  input  wire  logic                overcurrent_det,
  input  wire  logic                hall_det,
  input  wire  logic                awd_event,
  input  wire  logic                internal_reset_src,
  // LIN receiver
  input  wire  logic                lin_bus_level,
  output logic                      lin_rx_out,
  output logic                      wake_req,
  // Period input and power-stage gating
  input  wire  logic                limit_period_input,
  input  wire  logic [7:0]          limit_duty,
  input  wire  logic                high_side_cmd,
  input  wire  logic [3:0]          bridge_high_cmd,
  input  wire  logic [3:0]          bridge_low_cmd,
  input  wire  logic [3:0]          bridge_overlimit,
  output logic                      high_side_switch,
  output logic [3:0]                half_bridge_outputs_hi,
  output logic [3:0]                half_bridge_outputs_lo,
  // Open-drain interrupt line
  output logic                      irq_n_o,
  output logic                      irq_n_oe,
  // Open-drain reset line
  input  wire  logic                rst_line_i,
  output logic                      rst_line_o,
  output logic                      rst_line_oe,
  output logic                      rst_line_seen
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] next_sync1;
  logic [NSYNC-1:0] next_sync2;
  assign raw_in = {rst_line_i, limit_period_input, lin_bus_level, internal_reset_src, awd_event,
                   hall_det, overcurrent_det, temp_high_det, supply_high_det, stop_mode};

  // First stage feeds only the second
  always_comb begin
    next_sync1 = raw_in;
    next_sync2 = sync1;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= `SYNC_IDLE;
      sync2 <= `SYNC_IDLE;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // Supply-low detector sits in its own pair so its reset idle is clear
  logic lv1;
  logic lv2;
  logic next_lv1;
  logic next_lv2;
  always_comb begin
    next_lv1 = supply_low_det;
    next_lv2 = lv1;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lv1 <= 1'b0;
      lv2 <= 1'b0;
    end else begin
      lv1 <= next_lv1;
      lv2 <= next_lv2;
    end
  end

  logic s_stop, s_hv, s_ht, s_oc, s_hall, s_awd, s_intrst, s_lin, s_per, s_rst;
  assign {s_rst, s_per, s_lin, s_intrst, s_awd, s_hall, s_oc, s_ht, s_hv, s_stop} = sync2;

  // ==========================================================
  // Event detection, flags and enables
  // ==========================================================
  logic lin_prev;
  logic next_lin_prev;
  logic [`NUM_SRC-1:0] src_evt;
  logic [`NUM_SRC-1:0] next_flag;
  logic [`NUM_SRC-1:0] next_enable;

  always_comb begin
    src_evt = `SRC_ZERO;
    src_evt[`SRC_LV]   = lv2 & ~s_stop;
    src_evt[`SRC_HV]   = s_hv & ~s_stop;
    src_evt[`SRC_HT]   = s_ht & ~s_stop;
    src_evt[`SRC_LIN]  = lin_prev & ~s_lin;
    src_evt[`SRC_OC]   = s_oc;
    src_evt[`SRC_HALL] = s_hall;
    src_evt[`SRC_AWD]  = s_awd;
    next_lin_prev = s_lin;
    // Set beats a clear arriving in the same cycle
    next_flag = (irq_flag & ~flag_clear) | src_evt;
    // per-source enable written over the link
    next_enable = enable_we ? enable_wdata : irq_enable;
  end

  // enables and flags clear on reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_flag   <= `SRC_ZERO;
      irq_enable <= `SRC_ZERO;
      lin_prev   <= 1'b1;
    end else begin
      irq_flag   <= next_flag;
      irq_enable <= next_enable;
      lin_prev   <= next_lin_prev;
    end
  end

  // ==========================================================
  // Interrupt, wake-up and reset lines
  // ==========================================================
  logic irq_pend;
  logic next_irq_pend;
  logic wake;
  logic next_wake;
  logic rst_drive;
  logic next_rst_drive;
  logic rx;
  logic next_rx;
  always_comb begin
    // held while any enabled flag stands
    next_irq_pend  = |(next_flag & next_enable);
    // LIN edge wakes the system from stop
    next_wake      = s_stop & next_flag[`SRC_LIN] & next_enable[`SRC_LIN];
    // internal reset pulls the shared line
    next_rst_drive = s_intrst;
    // received bus level to the receive output
    next_rx        = s_lin;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_pend  <= 1'b0;
      wake      <= 1'b0;
      rst_drive <= 1'b0;
      rx        <= 1'b1;
    end else begin
      irq_pend  <= next_irq_pend;
      wake      <= next_wake;
      rst_drive <= next_rst_drive;
      rx        <= next_rx;
    end
  end

  assign irq_n_o     = 1'b0;
  assign irq_n_oe    = irq_pend;
  // reset pin driven low only, read back through synchroniser
  assign rst_line_o    = 1'b0;
  assign rst_line_oe   = rst_drive;
  assign rst_line_seen = ~s_rst;
  assign wake_req      = wake;
  assign lin_rx_out    = rx;

  // ==========================================================
  // Current-limit PWM from the external period
  // ==========================================================
  // Only the rising edges of the period input matter; duty is counted here
  logic per_prev;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] per_len;
  logic [PER_W-1:0] next_per_cnt;
  logic [PER_W-1:0] next_per_len;
  logic next_per_prev;
  logic [PER_W+7:0] on_time;
  die_irq_pkg::pwm_state_t st;
  die_irq_pkg::pwm_state_t next_st;
  logic per_edge;

  always_comb begin
    per_edge      = s_per & ~per_prev;
    next_per_prev = s_per;
    // Saturates while the period input stalls; an edge still restarts it
    next_per_cnt  = (&per_cnt) ? per_cnt : per_cnt + 1'b1;
    next_per_len  = per_len;
    on_time       = per_len * limit_duty;
    next_st       = st;
    case (st)
      die_irq_pkg::PWM_IDLE: begin
        if (per_edge) begin
          next_st      = die_irq_pkg::PWM_ON;
          next_per_cnt = '0;
        end
      end
      die_irq_pkg::PWM_ON: begin
        if (per_edge) begin
          next_per_len = per_cnt;
          next_per_cnt = '0;
        end else if (per_cnt >= on_time[PER_W+7:8]) begin
          next_st = die_irq_pkg::PWM_OFF;
        end
      end
      die_irq_pkg::PWM_OFF: begin
        if (per_edge) begin
          next_per_len = per_cnt;
          next_per_cnt = '0;
          next_st      = die_irq_pkg::PWM_ON;
        end
      end
      default: next_st = die_irq_pkg::PWM_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= die_irq_pkg::PWM_IDLE;
      per_cnt  <= '0;
      per_len  <= '0;
      per_prev <= 1'b0;
    end else begin
      st       <= next_st;
      per_cnt  <= next_per_cnt;
      per_len  <= next_per_len;
      per_prev <= next_per_prev;
    end
  end

  // ==========================================================
  // Power-stage gating
  // ==========================================================
  logic supply_fault;
  logic pwm_on;
  logic [3:0] hb_hi;
  logic [3:0] hb_lo;
  logic high_drive;
  logic [3:0] next_hb_hi;
  logic [3:0] next_hb_lo;
  logic next_high_drive;
  always_comb begin
    // supply fault removes every high-side drive
    supply_fault = lv2 & ~s_stop | s_hv & ~s_stop;
    pwm_on       = (st != die_irq_pkg::PWM_OFF);
    // inrush limited by the internal PWM
    next_high_drive = high_side_cmd & ~supply_fault & pwm_on;
    next_hb_hi   = supply_fault ? 4'h0 : bridge_high_cmd;
    // current limit chops the lower transistors only
    next_hb_lo   = bridge_low_cmd & ~(bridge_overlimit & {4{~pwm_on}});
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      high_drive <= 1'b0;
      hb_hi <= 4'h0;
      hb_lo <= 4'h0;
    end else begin
      high_drive <= next_high_drive;
      hb_hi <= next_hb_hi;
      hb_lo <= next_hb_lo;
    end
  end
  assign high_side_switch       = high_drive;
  assign half_bridge_outputs_hi = hb_hi;
  assign half_bridge_outputs_lo = hb_lo;

  // ==========================================================
  // Assertions
  // ==========================================================
  a_enable_reset_clear: assert property (@(posedge ref_clk) $rose(rstn) |-> irq_enable == `SRC_ZERO)
    else $error("enables not clear after reset");
  a_enable_write_takes: assert property (@(posedge ref_clk) disable iff (!rstn)
    enable_we |=> irq_enable == $past(enable_wdata))
    else $error("enable write lost");
  a_low_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    lv2 && !s_stop |=> irq_flag[`SRC_LV])
    else $error("low-supply flag not set");
  a_high_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_hv && !s_stop |=> irq_flag[`SRC_HV])
    else $error("high-supply flag not set");
  a_temp_stop_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_stop && !irq_flag[`SRC_HT] ##1 s_stop |-> !irq_flag[`SRC_HT])
    else $error("over-temp flag set in stop");
  a_fault_high_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    supply_fault |=> !high_side_switch && half_bridge_outputs_hi == 4'h0)
    else $error("high side on during supply fault");
  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    ##1 irq_n_oe == |(irq_flag & irq_enable))
    else $error("interrupt line mismatch");
  a_rst_pull: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_intrst |=> rst_line_oe && !rst_line_o)
    else $error("reset line not pulled");
endmodule // analog_die_interrupt_protect
`default_nettype wire

// *** die_irq_cfg.svh ***
// Constants for the analog die interrupt and protection block
`ifndef DIE_IRQ_CFG_SVH
`define DIE_IRQ_CFG_SVH
// Flag and enable bit positions
`define SRC_OC        0
`define SRC_HV        1
`define SRC_LV        2
`define SRC_HT        3
`define SRC_LIN       4
`define SRC_HALL      5
`define SRC_AWD       6
`define NUM_SRC       7
`define SRC_ZERO      7'h00
// Current-limit PWM duty as a fraction of the period, in 1/256 steps
`define DUTY_DEFAULT  8'h80
`define PER_WIDTH     20
// Synchroniser reset levels: pulled-up reset line and idle LIN bus read high
`define SYNC_IDLE     10'h280
`endif

// *** die_irq_pkg.sv ***
// Types for the analog die interrupt and protection block
`default_nettype none
package die_irq_pkg;
  typedef enum logic [1:0] {
    PWM_IDLE = 2'b00,
    PWM_ON   = 2'b01,
    PWM_OFF  = 2'b10
  } pwm_state_t;
endpackage
`default_nettype wire

// *** mcu_model.sv ***
// Microcontroller side model: enable transfers and the current-limit period source
`default_nettype none

module mcu_model #(
  parameter int HALF_PER = 250
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Enable transfer
  output var  logic [6:0] enable_wdata,
  output var  logic       enable_we,
  // Period source
  output var  logic       limit_period_input
);
  timeunit 1ns;
  timeprecision 1ns;

  int half_cnt;

  // Quiet transfer lines before the first write
  initial begin
    enable_wdata = 7'h00;
    enable_we    = 1'b0;
  end

  // period within range
  // 500 cycles at 10 MHz gives 20 kHz, the fastest allowed, to keep the run short
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      half_cnt           <= 0;
      limit_period_input <= 1'b0;
    end else if (half_cnt == HALF_PER - 1) begin
      half_cnt           <= 0;
      limit_period_input <= ~limit_period_input;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  // whole transfer per write
  // One strobe carries all seven enables, as one complete serial frame would
  task automatic write_en(input logic [6:0] v);
    @(posedge ref_clk);
    enable_wdata <= v;
    enable_we    <= 1'b1;
    @(posedge ref_clk);
    enable_we    <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
endmodule // mcu_model

`default_nettype wire

// *** analog_die_interrupt_protect_tb.sv ***
// Self-checking bench for the interrupt, reset and protection block
`include "die_irq_cfg.svh"
`default_nettype none

module analog_die_interrupt_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // Signals
  logic       ref_clk, rstn, we, per, stop, rsrc, hi_sw, rst_o, rst_oe, rst_seen, irq_o, irq_oe, lin_rx, wake;
  logic [6:0] wdata, det, clr, en, flag;
  logic [3:0] bh_cmd, bl_cmd, hi, lo, olim;
  logic [7:0] duty;
  wire        irq_pin = irq_oe ? irq_o : 1'b1;
  wire        rst_pin = rst_oe ? rst_o : 1'b1;
  int         n_errors, checks, seed, exp_en, exp_flag, cnt, exp_on, i, n_lo;
  int         en_q[$];

  // Clock at 10 MHz
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Instances
  mcu_model mcu_u (.ref_clk(ref_clk), .rstn(rstn), .enable_wdata(wdata), .enable_we(we), .limit_period_input(per));

  analog_die_interrupt_protect dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .enable_wdata(wdata), .enable_we(we), .flag_clear(clr),
    .irq_enable(en), .irq_flag(flag), .stop_mode(stop), .supply_low_det(det[`SRC_LV]),
    .supply_high_det(det[`SRC_HV]), .temp_high_det(det[`SRC_HT]), .overcurrent_det(det[`SRC_OC]),
    .hall_det(det[`SRC_HALL]), .awd_event(det[`SRC_AWD]), .internal_reset_src(rsrc),
    .lin_bus_level(~det[`SRC_LIN]), .lin_rx_out(lin_rx), .wake_req(wake), .limit_period_input(per),
    .limit_duty(duty), .high_side_cmd(1'b1), .bridge_high_cmd(bh_cmd), .bridge_low_cmd(bl_cmd),
    .bridge_overlimit(olim), .high_side_switch(hi_sw), .half_bridge_outputs_hi(hi),
    .half_bridge_outputs_lo(lo), .irq_n_o(irq_o), .irq_n_oe(irq_oe), .rst_line_i(rst_pin),
    .rst_line_o(rst_o), .rst_line_oe(rst_oe), .rst_line_seen(rst_seen));

  // ==========================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_det(input logic [6:0] v);
    @(posedge ref_clk);
    det <= v;
    tick(5);
  endtask

  // Flags against the model, and the pin as the pull-up leaves it
  task automatic cmp_state();
    check("irq_flag", flag, exp_flag);
    check("irq_pin", irq_pin, (exp_flag & exp_en) == 0);
  endtask

  task automatic set_en(input int v);
    mcu_u.write_en(v[6:0]);
    exp_en = v;
    cmp_state();
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the roughly 1900 cycles the tests need
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end

  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h5fac;
    {rstn, stop, rsrc, det, clr, olim, exp_en, exp_flag} = '0;
    bh_cmd = 4'hF;
    bl_cmd = 4'hA;
    duty = 8'h80;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(2);
    check("en_rst", en, 7'h00);
    check("lin_rx_rst", lin_rx, 1'b1);
    for (i = 0; i < 4; i++) begin
      en_q.push_back($random(seed) & 32'h7F);
      mcu_u.write_en(7'(en_q[$]));
      check("irq_enable", en, en_q.pop_front());
    end
    set_en(32'h7F);
    // Every source in turn, flags left standing
    for (i = 0; i < `NUM_SRC; i++) begin
      set_det(7'h01 << i);
      exp_flag = exp_flag | (1 << i);
      cmp_state();
      if (i == `SRC_LIN) check("lin_rx", lin_rx, 1'b0);
      if (i == `SRC_LV || i == `SRC_HV) begin
        check("high_off", {hi_sw, hi}, 5'h00);
        check("low_kept", lo, bl_cmd);
      end
      set_det(7'h00);
      check("high_back", hi, bh_cmd);
    end
    // Masking alone must release the line while flags stand
    set_en(0);
    set_en(32'h7F);
    @(posedge ref_clk);
    clr <= 7'h7F;
    @(posedge ref_clk);
    clr <= 7'h00;
    tick(2);
    exp_flag = 0;
    cmp_state();
    @(posedge ref_clk);
    stop <= 1'b1;
    set_det(7'h0E);
    cmp_state();
    set_det(7'h00);
    set_det(7'h10);
    exp_flag = 32'h10;
    cmp_state();
    check("wake_req", wake, 1'b1);
    @(posedge ref_clk);
    stop <= 1'b0;
    set_det(7'h00);
    @(posedge ref_clk);
    rsrc <= 1'b1;
    tick(5);
    check("rst_line", {rst_oe, rst_pin, rst_seen}, 3'b101);
    @(posedge ref_clk);
    rsrc <= 1'b0;
    tick(5);
    check("rst_free", {rst_oe, rst_pin, rst_seen}, 3'b010);
    // on-time from duty, period from input
    @(posedge ref_clk);
    duty <= 8'(8'h20 + ($random(seed) & 32'h9F));
    olim <= 4'hF;
    tick(1200);
    exp_on = duty * 500 / 256;
    cnt = 0;
    n_lo = 0;
    repeat (500) begin
      @(posedge ref_clk);
      #1;
      cnt += int'(hi_sw);
      n_lo += int'(lo == bl_cmd);
    end
    check("pwm_on", cnt >= exp_on - 3 && cnt <= exp_on + 3, 1'b1);
    // limit chops lower side only in off phase
    check("pwm_lo", n_lo >= exp_on - 3 && n_lo <= exp_on + 3, 1'b1);
    // Reset in mid-run clears enables and flags
    @(posedge ref_clk);
    rstn <= 1'b0;
    tick(2);
    check("en_rerst", {en, flag}, 14'h0000);
    @(posedge ref_clk);
    rstn <= 1'b1;
    tick(2);
    check("en_after", en, 7'h00);
    check("flag_after", flag, 7'h00);
    wrap_up();
  end
endmodule // analog_die_interrupt_protect_tb

`default_nettype wire
